// File: dac_cmd_chk.sv
`timescale 1ns/1ps
module dac_cmd_chk
   import dac_cmd_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Pins
   input wire logic i_chip_select_n,
   input wire logic o_serial_data,
   input wire logic i_clear_all_n,
   input wire logic i_shutdown_lockout_n,
   input wire logic o_user_output_pin,
   // Codes and state
   input wire logic [DATA_W-1:0] o_dac_a,
   input wire logic [DATA_W-1:0] o_dac_b,
   input wire logic [DATA_W-1:0] o_input_a,
   input wire logic [DATA_W-1:0] o_input_b,
   input wire logic o_shutdown_a,
   input wire logic o_shutdown_b,
   input wire logic o_output_mode
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // Cycles since the raw pins went high; saturating so long idles stay safe
   logic [7:0] cs_hi;
   logic [7:0] clr_hi;
   wire [4*DATA_W-1:0] regs = {o_dac_a, o_dac_b, o_input_a, o_input_b};
   wire dec_win = cs_hi >= 8'h02 && cs_hi <= 8'h0c;
   wire quiet = cs_hi >= 8'h0e;
   wire clr_ok = clr_hi >= 8'h08;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cs_hi <= 8'h00;
         clr_hi <= 8'h00;
      end else begin
         cs_hi <= i_chip_select_n ? cs_hi + {7'h00, cs_hi != 8'hff} : 8'h00;
         clr_hi <= i_clear_all_n ? clr_hi + {7'h00, clr_hi != 8'hff} : 8'h00;
      end
   end
   sequence s_clear_held; (!i_clear_all_n) [*6]; endsequence
   sequence s_lock_held; (!i_shutdown_lockout_n) [*8]; endsequence
   property p_power_up;
      $rose(i_nrst) |-> regs == '0 && !o_user_output_pin && !o_output_mode;
   endproperty
   property p_clear; s_clear_held |-> regs == '0; endproperty
   property p_lock_hold;
      s_lock_held |=> !$rose(o_shutdown_a) && !$rose(o_shutdown_b);
   endproperty
   property p_lock_wake;
      $fell(i_shutdown_lockout_n) |-> ##[1:8] !o_shutdown_a && !o_shutdown_b;
   endproperty
   property p_idle_regs;
      quiet && clr_ok |-> $stable(regs) && $stable(o_user_output_pin)
         && $stable(o_output_mode);
   endproperty
   property p_idle_sdo; quiet |-> $stable(o_serial_data); endproperty
   property p_load_win;
      ($changed(o_input_a) || $changed(o_input_b)) && clr_ok |-> dec_win;
   endproperty
   property p_cfg_win;
      $changed(o_user_output_pin) || $changed(o_output_mode) |-> dec_win;
   endproperty
   a_power_up: assert property (p_power_up) else $error("bad reset");
   a_clear: assert property (p_clear) else $error("clear failed");
   a_lock_hold: assert property (p_lock_hold) else $error("lockout");
   a_lock_wake: assert property (p_lock_wake) else $error("no wake");
   a_idle_regs: assert property (p_idle_regs) else $error("idle");
   a_idle_sdo: assert property (p_idle_sdo) else $error("sdo idle");
   a_load_win: assert property (p_load_win) else $error("load");
   a_cfg_win: assert property (p_cfg_win) else $error("cfg");
endmodule
bind dual_dac_serial_command_decoder dac_cmd_chk chk (.i_clk(i_clk),
   .i_nrst(i_nrst), .i_chip_select_n(i_chip_select_n),
   .o_serial_data(o_serial_data), .i_clear_all_n(i_clear_all_n),
   .i_shutdown_lockout_n(i_shutdown_lockout_n), .o_dac_a(o_dac_a),
   .o_user_output_pin(o_user_output_pin), .o_dac_b(o_dac_b),
   .o_input_a(o_input_a), .o_input_b(o_input_b), .o_shutdown_a(o_shutdown_a),
   .o_shutdown_b(o_shutdown_b), .o_output_mode(o_output_mode));

// File: dac_cmd_pkg.sv
package dac_cmd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Word layout
   localparam int WORD_W = 16;
   localparam int DATA_W = 10;
   localparam int CHAN_BIT = 15;
   localparam int CTRL_HI = 14;
   localparam int CTRL_LO = 13;
   localparam int DATA_HI = 12;
   localparam int DATA_LO = 3;
   localparam int EXT_HI = 12;
   localparam int EXT_LO = 10;
   localparam int MODE_BIT = 9;

   ////////////////////////////////////////////////////////////////////////
   // Control field codes
   localparam logic [1:0] CTRL_EXT_OR_RECALL = 2'h0;
   localparam logic [1:0] CTRL_LOAD_INPUT = 2'h1;
   localparam logic [1:0] CTRL_LOAD_UPDATE = 2'h2;
   localparam logic [1:0] CTRL_DIRECT_OR_OFF = 2'h3;

   // Extended codes, data bits 9 to 7
   localparam logic [2:0] EXT_NOP = 3'h0;
   localparam logic [2:0] EXT_RECALL_A = 3'h1;
   localparam logic [2:0] EXT_PIN_LOW = 3'h2;
   localparam logic [2:0] EXT_PIN_HIGH = 3'h3;
   localparam logic [2:0] EXT_MODE = 3'h4;
   localparam logic [2:0] EXT_RECALL_B = 3'h5;
   localparam logic [2:0] EXT_OFF_A = 3'h6;
   localparam logic [2:0] EXT_OFF_B = 3'h7;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [DATA_W-1:0] CODE_RESET = 10'h000;
   localparam logic [WORD_W-1:0] SHIFT_RESET = 16'h0000;
   localparam logic PIN_RESET = 1'b0;
   localparam logic MODE_RESET = 1'b0;
   localparam logic OFF_RESET = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser width: cs, clock, data, clear, lockout
   localparam int PIN_N = 5;
   localparam logic [PIN_N-1:0] PIN_IDLE = 5'h1b;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_frame = 2'b01,
      st_decode = 2'b11
   } frame_state_t;

endpackage

// File: dual_dac_serial_command_decoder.sv
`timescale 1ns/1ps
// Behaviour
// (R1) Word is 16 bits MSB first: channel, two control, ten data, three trailing.
// (R2) Chip select high: serial clock and data ignored, interface idle.
// (R3) Chip select low: data bit shifted in on each serial clock rise.
// (R4) Chip select rise decodes the word into input and DAC registers.
// (R5) Host keeps chip select low for one 16-bit or two 8-bit transfers.
// (R6) Control 01 loads addressed input register only.
// (R7) Control 10 loads addressed input register, then updates both DAC registers.
// (R8) Channel 0 control 11 loads both DAC registers directly, wakes both.
// (R9) Channel 1 control 00 recalls both input registers, wakes both.
// (R10) Channel 1 control 11 shuts both channels while lockout input high.
// (R11) All zero header: data bits 9 to 6 form extended command; 000 does nothing.
// (R12) Ext 001/101 recall and start A/B; 110/111 shut A/B if allowed.
// (R13) Ext 010 drives user pin low, 011 high; low after power-up.
// (R14) Ext 1001 selects output on rising edge, 1000 falling edge, default.
// (R15) Host sends trailing bits as zeros.
// (R16) Serial output is final shift stage, lag 16 or 15.5 cycles.
// (R17) Shutdown keeps interface running and input registers intact.
// (R18) Host waits 20 us after wake before trusting outputs.
// (R19) Lockout low blocks shutdown; falling lockout wakes channels.
// (R20) Clear low zeroes all input and DAC registers.
// (R21) Serial clock no faster than 10 MHz.
// (R22) Power-up clears all input and DAC registers.
// (R23) Extra clocks: only the last 16 bits shifted in are decoded.
module dual_dac_serial_command_decoder
   import dac_cmd_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Serial link pins
   input wire logic i_chip_select_n,
   input wire logic i_serial_clock,
   input wire logic i_serial_data,
   output logic o_serial_data,
   // Control pins
   input wire logic i_clear_all_n,
   input wire logic i_shutdown_lockout_n,
   output logic o_user_output_pin,
   // Converter codes and power state
   output logic [DATA_W-1:0] o_dac_a,
   output logic [DATA_W-1:0] o_dac_b,
   output logic [DATA_W-1:0] o_input_a,
   output logic [DATA_W-1:0] o_input_b,
   output logic o_shutdown_a,
   output logic o_shutdown_b,
   output logic o_output_mode
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [PIN_N-1:0] pins;
   logic cs_n;
   logic sclk;
   logic sdin;
   logic clear_all_n;
   logic shutdown_lockout_n;

   pin_sync #(
      .WIDTH(PIN_N),
      .IDLE(PIN_IDLE)
   ) u_pin_sync (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_pin({i_chip_select_n, i_serial_clock, i_serial_data,
              i_clear_all_n, i_shutdown_lockout_n}),
      .o_level(pins)
   );

   assign cs_n = pins[4];
   assign sclk = pins[3];
   assign sdin = pins[2];
   assign clear_all_n = pins[1];
   assign shutdown_lockout_n = pins[0];

   ////////////////////////////////////////////////////////////////////////
   // Edge finding on the filtered levels
   logic sclk_d;
   logic cs_n_d;
   logic lockout_d;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         // Idle level of the clock pin, so reset leaves no false rise
         sclk_d <= 1'b1;
         cs_n_d <= 1'b1;
         lockout_d <= 1'b1;
      end else begin
         sclk_d <= sclk;
         cs_n_d <= cs_n;
         lockout_d <= shutdown_lockout_n;
      end
   end

   wire sclk_rise = sclk & ~sclk_d;
   wire sclk_fall = ~sclk & sclk_d;
   wire cs_rise = cs_n & ~cs_n_d;
   wire lockout_fall = ~shutdown_lockout_n & lockout_d;

   ////////////////////////////////////////////////////////////////////////
   // Frame state
   frame_state_t state;
   frame_state_t next_state;

   always_comb begin
      next_state = state;
      case (state)
         st_idle: begin
            if (!cs_n) begin
               next_state = st_frame;
            end
         end
         st_frame: begin
            if (cs_rise) begin
               next_state = st_decode; // [R4]
            end
         end
         st_decode: begin
            next_state = cs_n ? st_idle : st_frame;
         end
         default: begin
            next_state = st_idle;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= st_idle;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shift register
   // Clocks seen while chip select is high never reach the shifter.
   logic [WORD_W-1:0] shift;
   wire framed = (state == st_frame) & ~cs_n; // [R2]
   wire shift_en = framed & sclk_rise; // [R3]
   // Older bits fall off the top, so only the last 16 survive
   wire [WORD_W-1:0] next_shift = {shift[WORD_W-2:0], sdin}; // [R23]

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         shift <= SHIFT_RESET;
      end else if (shift_en) begin
         shift <= next_shift; // [R1] [R3]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial output
   // Mode 1 samples the top stage on the rising edge before it shifts,
   // half a clock behind mode 0 which takes it on the falling edge.
   wire dout_rise = framed & sclk_rise & o_output_mode;
   wire dout_fall = framed & sclk_fall & ~o_output_mode;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_serial_data <= 1'b0;
      end else if (dout_rise | dout_fall) begin
         o_serial_data <= shift[WORD_W-1]; // [R16]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Word decode
   // Trailing bits are not checked; the host keeps them zero.
   wire decode = (state == st_decode); // [R4]
   wire chan = shift[CHAN_BIT];
   wire [1:0] ctrl = {shift[CTRL_HI], shift[CTRL_LO]};
   wire [DATA_W-1:0] data = shift[DATA_HI:DATA_LO];
   wire [2:0] ext = shift[EXT_HI:EXT_LO];
   wire ext_mode = shift[MODE_BIT];

   wire is_load = decode & (ctrl == CTRL_LOAD_INPUT);
   wire is_load_upd = decode & (ctrl == CTRL_LOAD_UPDATE);
   wire is_direct = decode & ~chan & (ctrl == CTRL_DIRECT_OR_OFF);
   wire is_recall_all = decode & chan & (ctrl == CTRL_EXT_OR_RECALL);
   wire is_off_all = decode & chan & (ctrl == CTRL_DIRECT_OR_OFF);
   wire is_ext = decode & ~chan & (ctrl == CTRL_EXT_OR_RECALL); // [R11]

   wire ext_recall_a = is_ext & (ext == EXT_RECALL_A);
   wire ext_recall_b = is_ext & (ext == EXT_RECALL_B);
   wire ext_off_a = is_ext & (ext == EXT_OFF_A);
   wire ext_off_b = is_ext & (ext == EXT_OFF_B);
   wire ext_pin_low = is_ext & (ext == EXT_PIN_LOW);
   wire ext_pin_high = is_ext & (ext == EXT_PIN_HIGH);
   wire ext_mode_sel = is_ext & (ext == EXT_MODE);

   // Input register writes
   wire load_any = is_load | is_load_upd; // [R6] [R7]
   wire load_a = load_any & ~chan;
   wire load_b = load_any & chan;

   // Both inputs then both DAC registers, the new word included
   wire [DATA_W-1:0] next_input_a = load_a ? data : o_input_a;
   wire [DATA_W-1:0] next_input_b = load_b ? data : o_input_b;

   // DAC register writes
   wire upd_a = is_load_upd | is_recall_all | ext_recall_a; // [R7] [R9]
   wire upd_b = is_load_upd | is_recall_all | ext_recall_b; // [R12]

   wire [DATA_W-1:0] next_dac_a = is_direct ? data : // [R8]
                                  upd_a ? next_input_a : o_dac_a;
   wire [DATA_W-1:0] next_dac_b = is_direct ? data :
                                  upd_b ? next_input_b : o_dac_b;

   ////////////////////////////////////////////////////////////////////////
   // Code registers
   // Clear is a level and wins over a word decoded at the same time.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_input_a <= CODE_RESET; // [R22]
         o_input_b <= CODE_RESET;
      end else if (!clear_all_n) begin
         o_input_a <= CODE_RESET; // [R20]
         o_input_b <= CODE_RESET;
      end else begin
         o_input_a <= next_input_a; // [R6]
         o_input_b <= next_input_b; // [R17]
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_dac_a <= CODE_RESET; // [R22]
         o_dac_b <= CODE_RESET;
      end else if (!clear_all_n) begin
         o_dac_a <= CODE_RESET; // [R20]
         o_dac_b <= CODE_RESET;
      end else begin
         o_dac_a <= next_dac_a;
         o_dac_b <= next_dac_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shutdown flags
   // Lockout low holds both channels awake; its falling edge also wakes
   // them, and the DAC registers still hold the pre-shutdown codes.
   wire allow_off = shutdown_lockout_n; // [R10] [R19]
   wire wake_a = is_direct | is_recall_all | ext_recall_a | lockout_fall;
   wire wake_b = is_direct | is_recall_all | ext_recall_b | lockout_fall;
   wire off_a = allow_off & (is_off_all | ext_off_a); // [R12]
   wire off_b = allow_off & (is_off_all | ext_off_b); // [R10]

   wire next_shutdown_a = wake_a ? 1'b0 : (off_a | o_shutdown_a); // [R8] [R9]
   wire next_shutdown_b = wake_b ? 1'b0 : (off_b | o_shutdown_b); // [R19]

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_shutdown_a <= OFF_RESET;
         o_shutdown_b <= OFF_RESET;
      end else begin
         o_shutdown_a <= next_shutdown_a;
         o_shutdown_b <= next_shutdown_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // User pin and output mode
   wire next_pin = ext_pin_high ? 1'b1 : // [R13]
                   ext_pin_low ? 1'b0 : o_user_output_pin;
   wire next_mode = ext_mode_sel ? ext_mode : o_output_mode; // [R14]

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_user_output_pin <= PIN_RESET; // [R13]
         o_output_mode <= MODE_RESET; // [R14]
      end else begin
         o_user_output_pin <= next_pin;
         o_output_mode <= next_mode;
      end
   end

endmodule

// File: host_model.sv
`timescale 1ns/1ps
module host_model (
   // Clock
   input wire logic i_clk,
   // Serial link
   output logic o_cs_n,
   output logic o_sclk,
   output logic o_data,
   // Daisy-chain output of the block
   input wire logic i_sdo
);
   logic [15:0] echo;
   // 20 clocks a half gives the 160 ns link clock
   localparam int HALF = 20;
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b1;
      o_data = 1'b0;
      echo = 16'h0000;
   end
   task automatic bit_out(input logic b);
      o_sclk <= 1'b0;
      o_data <= b;
      repeat (HALF) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (HALF) @(posedge i_clk);
      // Half a period after the rise the output is settled in both modes
      echo = {echo[14:0], i_sdo};
   endtask
   task automatic send(input logic [15:0] w, input int npre);
      o_cs_n <= 1'b0;
      repeat (HALF) @(posedge i_clk);
      for (int i = 0; i < npre; i++) bit_out(i[0]);
      for (int i = 15; i >= 0; i--) bit_out(w[i]);
      o_cs_n <= 1'b1;
      // Undriven data has no pull, so it moves away from the last bit
      o_data <= ~w[0];
      repeat (2 * HALF) @(posedge i_clk);
   endtask
   task automatic noise();
      for (int i = 0; i < 16; i++) bit_out(i[0]);
   endtask
endmodule

// File: pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] IDLE = '0
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Raw pins and filtered levels
   input wire logic [WIDTH-1:0] i_pin,
   output logic [WIDTH-1:0] o_level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
   wire [WIDTH-1:0] next_level = (agree & stage3) | (~agree & o_level);

   // Stage one feeds only stage two
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         stage1 <= IDLE;
         stage2 <= IDLE;
         stage3 <= IDLE;
         o_level <= IDLE;
      end else begin
         stage1 <= i_pin;
         stage2 <= stage1;
         stage3 <= stage2;
         o_level <= next_level;
      end
   end

endmodule

// File: tb_dual_dac_serial_command_decoder.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_dual_dac_serial_command_decoder
   import dac_cmd_pkg::*;
   ;
   logic i_clk, i_nrst, cs_n, sclk, sdi, sdo, clr_n, lk_n, pin, mode;
   logic sd_a, sd_b, x_sa, x_sb, x_pin, x_md;
   logic [DATA_W-1:0] dac_a, dac_b, in_a, in_b, x_da, x_db, x_ia, x_ib;
   int error_cnt = 0;
   int tests_run = 0;
   logic [3:0] ext [6] = '{4'h0, 4'h6, 4'h4, 4'h9, 4'h8, 4'h9};
   logic [15:0] x_sh;
   dual_dac_serial_command_decoder dut (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_chip_select_n(cs_n), .i_serial_clock(sclk), .i_serial_data(sdi),
      .o_serial_data(sdo), .i_clear_all_n(clr_n), .i_shutdown_lockout_n(lk_n),
      .o_user_output_pin(pin), .o_dac_a(dac_a), .o_dac_b(dac_b),
      .o_input_a(in_a), .o_input_b(in_b), .o_shutdown_a(sd_a),
      .o_shutdown_b(sd_b), .o_output_mode(mode));
   host_model host (.i_clk(i_clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_data(sdi),
      .i_sdo(sdo));
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic check_all();
      `CHK({dac_a, dac_b, in_a, in_b, sd_a, sd_b, pin, mode},
         {x_da, x_db, x_ia, x_ib, x_sa, x_sb, x_pin, x_md})
   endtask
   // Send one word, then update the expected state and compare
   task automatic cmd(input logic [15:0] w, input int npre);
      logic [DATA_W-1:0] d;
      logic [15:0] x_echo;
      d = w[DATA_HI:DATA_LO];
      // The output replays what the shifter held before the last 16 bits
      x_echo = x_sh;
      for (int i = 0; i < npre; i++)
         x_echo = {x_echo[14:0], i[0]};
      tick(1);
      host.send(w, npre);
      `CHK(host.echo, x_echo)
      x_sh = w;
      case (w[15:13])
         3'h1, 3'h5, 3'h2, 3'h6: begin
            if (w[15])
               x_ib = d;
            else
               x_ia = d;
            if (w[14])
               {x_da, x_db} = {x_ia, x_ib};
         end
         3'h3: {x_da, x_db, x_sa, x_sb} = {d, d, 2'b00};
         3'h4: {x_da, x_db, x_sa, x_sb} = {x_ia, x_ib, 2'b00};
         3'h7: {x_sa, x_sb} = {x_sa | lk_n, x_sb | lk_n};
         default: case (d[9:7])
            3'h1: {x_da, x_sa} = {x_ia, 1'b0};
            3'h5: {x_db, x_sb} = {x_ib, 1'b0};
            3'h6: x_sa = x_sa | lk_n;
            3'h7: x_sb = x_sb | lk_n;
            3'h2, 3'h3: x_pin = d[7];
            3'h4: x_md = d[6];
            default: ;
         endcase
      endcase
      check_all();
   endtask
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   initial begin
      i_nrst = 1'b0;
      clr_n = 1'b1;
      lk_n = 1'b1;
      {x_da, x_db, x_ia, x_ib, x_sa, x_sb, x_pin, x_md} = '0;
      x_sh = SHIFT_RESET;
      tick(2);
      i_nrst <= 1'b1;
      tick(4);
      check_all();
      cmd({3'h1, 10'h2a5, 3'h0}, 0);
      cmd({3'h5, 10'h15a, 3'h0}, 0);
      cmd({3'h2, 10'h3ff, 3'h0}, 0);
      cmd({3'h0, 3'h6, 7'h00, 3'h0}, 0);
      cmd({3'h5, 10'h001, 3'h0}, 0);
      cmd({3'h0, 3'h1, 7'h7f, 3'h0}, 0);
      cmd({3'h0, 3'h7, 7'h00, 3'h0}, 0);
      cmd({3'h0, 3'h5, 7'h00, 3'h0}, 0);
      cmd({3'h6, 10'h2c4, 3'h0}, 0);
      lk_n <= 1'b0;
      cmd({3'h7, 13'h0000}, 0);
      cmd({3'h0, 3'h6, 7'h00, 3'h0}, 0);
      lk_n <= 1'b1;
      cmd({3'h7, 13'h0000}, 0);
      lk_n <= 1'b0;
      tick(10);
      {x_sa, x_sb} = 2'b00;
      check_all();
      lk_n <= 1'b1;
      cmd({3'h7, 13'h0000}, 0);
      cmd({3'h1, 10'h0f0, 3'h0}, 0);
      cmd({3'h4, 13'h1ff8}, 0);
      // Host lets the outputs settle after a wake before relying on them
      tick(5000);
      check_all();
      cmd({3'h7, 13'h0000}, 0);
      cmd({3'h3, 10'h1c3, 3'h0}, 0);
      for (int i = 0; i < 6; i++)
         cmd({3'h0, ext[i], 6'h15, 3'h0}, 0);
      cmd({3'h1, 10'h155, 3'h0}, 4);
      tick(1);
      host.noise();
      check_all();
      clr_n <= 1'b0;
      tick(10);
      {x_da, x_db, x_ia, x_ib} = '0;
      check_all();
      clr_n <= 1'b1;
      cmd({3'h0, 3'h1, 7'h00, 3'h0}, 0);
      complete_run();
   end
endmodule
